// File: rtl/uhp_desc_decode.sv
`timescale 1ns/1ps
`default_nettype none

module uhp_desc_decode
	import uhp_pkg::*;
(
	// Raw descriptor words
	input  wire logic [31:0]      addrWord,
	input  wire logic [31:0]      sizeWord,
	// Decoded fields
	output logic      [31:0]      bufAddr,
	output logic                  autoZlp,
	output logic      [PKT_W-1:0] maxPacket,
	output logic                  isoOnly,
	output logic      [CNT_W-1:0] multiPacket,
	output logic      [CNT_W-1:0] byteCount
);

	logic [2:0] sizeCode;

	assign sizeCode = sizeWord[SIZE_HI:SIZE_LO];

	// Low two address bits are read-only zero
	assign bufAddr     = addrWord & ADDR_RW_MASK;
	assign autoZlp     = sizeWord[AUTO_ZERO_LENGTH_PACKET_BIT];
	assign multiPacket = sizeWord[MPS_HI:MPS_LO];
	assign byteCount   = sizeWord[BC_HI:BC_LO];
	assign isoOnly     = (sizeCode >= SIZE_ISO_MIN);

	// Packet size from code: 8 shifted by code, top code is 1023
	always_comb
	begin
		if (sizeCode == SIZE_MAX)
			maxPacket = PKT_FS_MAX;
		else
			maxPacket = PKT_BASE << sizeCode;
	end

endmodule : uhp_desc_decode

`default_nettype wire

// File: rtl/uhp_pipe_ctrl.sv
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module uhp_pipe_ctrl
	import uhp_pkg::*;
#(
	parameter int unsigned PIPES = 8
)
(
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [PADDR_W-1:0]   paddr,
	input  wire logic [DATA_W-1:0]    pwdata,
	output logic      [DATA_W-1:0]    prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Pipe engine events
	input  wire logic                 busReset,
	input  wire logic [PIPES*EV_W-1:0] pipeEvents,
	// Descriptor fetch and accumulate requests
	input  wire logic                 fetchStart,
	input  wire logic [7:0]           fetchPipe,
	input  wire logic                 fetchBank,
	input  wire logic                 accumStart,
	input  wire logic [CNT_W-1:0]     accumBytes,
	// System memory port
	output logic      [31:0]          memAddr,
	output logic                      memRead,
	output logic                      memWrite,
	output logic      [31:0]          memWdata,
	input  wire logic [31:0]          memRdata,
	input  wire logic                 memAck,
	// Decoded descriptor
	output logic                      fetchDone,
	output logic      [31:0]          bufAddr,
	output logic                      autoZlp,
	output logic      [PKT_W-1:0]     maxPacket,
	output logic                      isoOnly,
	output logic      [CNT_W-1:0]     multiPacket,
	output logic      [CNT_W-1:0]     byteCount,
	// Interrupt
	output logic                      irq
);

	// ****************************************************************
	// APB handshake and decode
	// ****************************************************************
	logic              pready_reg;
	logic              pready_next;
	logic [DATA_W-1:0] prdata_reg;
	logic [DATA_W-1:0] prdata_next;
	logic              pslverr_reg;
	logic              pslverr_next;
	logic [IDX_W-1:0]  idx;
	logic              alignOk;
	logic              accessPh;
	logic              wrTake;
	logic [EV_W-1:0]   wEv;

	assign idx      = paddr[PADDR_W-1:IDX_LSB];
	assign alignOk  = (paddr[IDX_LSB-1:0] == '0);
	assign accessPh = psel && penable && !pready_reg;
	assign wrTake   = psel && penable && pready_reg && pwrite;
	assign wEv      = pwdata[EV_W-1:0];

	// ****************************************************************
	// Own control registers
	// ****************************************************************
	logic [PIPES-1:0] pipeEn_reg;
	logic [PIPES-1:0] pipeEn_next;
	logic [31:0]      descBase_reg;
	logic [31:0]      descBase_next;

	// Pipe enable and descriptor base writes
	always_comb
	begin
		pipeEn_next   = pipeEn_reg;
		descBase_next = descBase_reg;
		if (wrTake && alignOk && idx == PIPE_EN_IDX)
			pipeEn_next = pwdata[PIPES-1:0];
		if (wrTake && alignOk && idx == DESC_BASE_IDX)
			descBase_next = pwdata & ADDR_RW_MASK;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			pipeEn_reg   <= '0;
			descBase_reg <= '0;
		end
		else
		begin
			pipeEn_reg   <= pipeEn_next;
			descBase_reg <= descBase_next;
		end
	end

	// ****************************************************************
	// Per-pipe enable masks and flags
	// ****************************************************************
	logic [PIPES-1:0]      hitClr;
	logic [PIPES-1:0]      hitSet;
	logic [PIPES-1:0]      hitFlag;
	logic [PIPES-1:0]      pipeReq;
	logic [EV_W-1:0]       maskOf [PIPES];
	logic [EV_W-1:0]       flagOf [PIPES];

	genvar gi;
	generate
		for (gi = 0; gi < PIPES; gi++)
		begin : g_pipe
			localparam logic [IDX_W-1:0] OFS = IDX_W'(gi * PIPE_STRIDE);

			// Port decode per pipe
			assign hitClr[gi]  = alignOk && idx == CLR_IDX + OFS;
			assign hitSet[gi]  = alignOk && idx == SET_IDX + OFS;
			assign hitFlag[gi] = alignOk && idx == FLAG_IDX + OFS;

			uhp_pipe_irq u_irq
			(
				.clock      (clock),
				.rst_n      (rst_n),
				.pipeEn     (pipeEn_reg[gi]),
				.busReset   (busReset),
				.clrWr      (wrTake && hitClr[gi]),
				.setWr      (wrTake && hitSet[gi]),
				.flagClrWr  (wrTake && hitFlag[gi]),
				.wdata      (wEv),
				.eventIn    (pipeEvents[gi*EV_W +: EV_W]),
				.enableMask (maskOf[gi]),
				.eventFlags (flagOf[gi]),
				.irqReq     (pipeReq[gi])
			);
		end
	endgenerate

	// ****************************************************************
	// Read data, ready and error
	// ****************************************************************
	always_comb
	begin
		prdata_next  = prdata_reg;
		pslverr_next = 1'b0;
		pready_next  = accessPh;
		if (accessPh)
		begin
			prdata_next  = '0;
			pslverr_next = 1'b1;
			if (alignOk && idx == PIPE_EN_IDX)
			begin
				prdata_next[PIPES-1:0] = pipeEn_reg;
				pslverr_next           = 1'b0;
			end
			if (alignOk && idx == DESC_BASE_IDX)
			begin
				prdata_next  = descBase_reg;
				pslverr_next = 1'b0;
			end
			for (int i = 0; i < PIPES; i++)
			begin
				// Both ports read the same mask, upper bits zero
				if (hitClr[i] || hitSet[i])
				begin
					prdata_next[EV_W-1:0] = maskOf[i];
					pslverr_next          = 1'b0;
				end
				if (hitFlag[i])
				begin
					prdata_next[EV_W-1:0] = flagOf[i];
					pslverr_next          = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			pready_reg  <= 1'b0;
			prdata_reg  <= '0;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			pready_reg  <= pready_next;
			prdata_reg  <= prdata_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign pready  = pready_reg;
	assign prdata  = prdata_reg;
	assign pslverr = pslverr_reg;

	// ****************************************************************
	// Interrupt line
	// ****************************************************************
	logic irq_reg;
	logic irq_next;

	// Any pipe request holds the line high
	always_comb
	begin
		irq_next = |pipeReq;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			irq_reg <= 1'b0;
		else
			irq_reg <= irq_next;
	end

	assign irq = irq_reg;

	// ****************************************************************
	// Descriptor fetch and accumulate engine
	// ****************************************************************
	uhp_fetch_t       state_reg;
	uhp_fetch_t       state_next;
	logic [31:0]      bankBase_reg;
	logic [31:0]      bankBase_next;
	logic [31:0]      addrWord_reg;
	logic [31:0]      addrWord_next;
	logic [31:0]      sizeWord_reg;
	logic [31:0]      sizeWord_next;
	logic [31:0]      memAddr_reg;
	logic [31:0]      memAddr_next;
	logic             memRead_reg;
	logic             memRead_next;
	logic             memWrite_reg;
	logic             memWrite_next;
	logic [31:0]      memWdata_reg;
	logic [31:0]      memWdata_next;
	logic             done_reg;
	logic             done_next;
	logic [31:0]      pipeOfs;
	logic [CNT_W-1:0] mpsSum;

	assign pipeOfs = 32'(DESC_PIPE_STRIDE * 32'(fetchPipe));
	assign mpsSum  = CNT_W'(sizeWord_reg[MPS_HI:MPS_LO] + accumBytes);

	// Next state of the engine
	always_comb
	begin
		state_next    = state_reg;
		bankBase_next = bankBase_reg;
		addrWord_next = addrWord_reg;
		sizeWord_next = sizeWord_reg;
		memAddr_next  = memAddr_reg;
		memRead_next  = memRead_reg;
		memWrite_next = memWrite_reg;
		memWdata_next = memWdata_reg;
		done_next     = 1'b0;
		case (state_reg)
			FS_IDLE:
			begin
				if (fetchStart)
				begin
					// Bank 1 sits one bank offset above bank 0
					bankBase_next = descBase_reg + pipeOfs
						+ (fetchBank ? DESC_BANK_OFF : '0);
					memAddr_next  = descBase_reg + pipeOfs
						+ (fetchBank ? DESC_BANK_OFF : '0)
						+ DESC_ADDR_OFF;
					memRead_next  = 1'b1;
					state_next    = FS_ADDR;
				end
				else if (accumStart)
				begin
					// Add transferred bytes to the multi-packet field
					memAddr_next  = bankBase_reg + DESC_SIZE_OFF;
					memWdata_next = sizeWord_reg;
					memWdata_next[MPS_HI:MPS_LO] = mpsSum;
					sizeWord_next = memWdata_next;
					memWrite_next = 1'b1;
					state_next    = FS_WB;
				end
			end
			FS_ADDR:
			begin
				if (memAck)
				begin
					addrWord_next = memRdata;
					memAddr_next  = bankBase_reg + DESC_SIZE_OFF;
					state_next    = FS_SIZE;
				end
			end
			FS_SIZE:
			begin
				if (memAck)
				begin
					sizeWord_next = memRdata;
					memRead_next  = 1'b0;
					state_next    = FS_DONE;
				end
			end
			FS_DONE:
			begin
				done_next  = 1'b1;
				state_next = FS_IDLE;
			end
			FS_WB:
			begin
				if (memAck)
				begin
					memWrite_next = 1'b0;
					state_next    = FS_IDLE;
				end
			end
			default:
			begin
				memRead_next  = 1'b0;
				memWrite_next = 1'b0;
				state_next    = FS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			state_reg    <= FS_IDLE;
			bankBase_reg <= '0;
			addrWord_reg <= '0;
			sizeWord_reg <= '0;
			memAddr_reg  <= '0;
			memRead_reg  <= 1'b0;
			memWrite_reg <= 1'b0;
			memWdata_reg <= '0;
			done_reg     <= 1'b0;
		end
		else
		begin
			state_reg    <= state_next;
			bankBase_reg <= bankBase_next;
			addrWord_reg <= addrWord_next;
			sizeWord_reg <= sizeWord_next;
			memAddr_reg  <= memAddr_next;
			memRead_reg  <= memRead_next;
			memWrite_reg <= memWrite_next;
			memWdata_reg <= memWdata_next;
			done_reg     <= done_next;
		end
	end

	assign memAddr   = memAddr_reg;
	assign memRead   = memRead_reg;
	assign memWrite  = memWrite_reg;
	assign memWdata  = memWdata_reg;
	assign fetchDone = done_reg;

	// ****************************************************************
	// Field decode of the held descriptor words
	// ****************************************************************
	uhp_desc_decode u_dec
	(
		.addrWord    (addrWord_reg),
		.sizeWord    (sizeWord_reg),
		.bufAddr     (bufAddr),
		.autoZlp     (autoZlp),
		.maxPacket   (maxPacket),
		.isoOnly     (isoOnly),
		.multiPacket (multiPacket),
		.byteCount   (byteCount)
	);

endmodule : uhp_pipe_ctrl

`default_nettype wire

// File: rtl/uhp_pipe_irq.sv
`timescale 1ns/1ps
`default_nettype none

module uhp_pipe_irq
	import uhp_pkg::*;
(
	// Clock and reset
	input  wire logic            clock,
	input  wire logic            rst_n,
	// Pipe state
	input  wire logic            pipeEn,
	input  wire logic            busReset,
	// Register writes
	input  wire logic            clrWr,
	input  wire logic            setWr,
	input  wire logic            flagClrWr,
	input  wire logic [EV_W-1:0] wdata,
	// Events from the pipe engine
	input  wire logic [EV_W-1:0] eventIn,
	// State
	output logic      [EV_W-1:0] enableMask,
	output logic      [EV_W-1:0] eventFlags,
	output logic                 irqReq
);

	logic [EV_W-1:0] enable_reg;
	logic [EV_W-1:0] enable_next;
	logic [EV_W-1:0] flag_reg;
	logic [EV_W-1:0] flag_next;

	// Next enable mask and flags
	always_comb
	begin
		enable_next = enable_reg;
		if (clrWr)
			enable_next = enable_next & ~wdata;
		if (setWr)
			enable_next = enable_next | wdata;
		if (busReset || !pipeEn)
			enable_next = EV_RESET;
		flag_next = flag_reg;
		if (flagClrWr)
			flag_next = flag_next & ~wdata;
		flag_next = flag_next | eventIn; // Set wins over clear
	end

	// State registers
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			enable_reg <= EV_RESET;
			flag_reg   <= EV_RESET;
		end
		else
		begin
			enable_reg <= enable_next;
			flag_reg   <= flag_next;
		end
	end

	assign enableMask = enable_reg;
	assign eventFlags = flag_reg;
	assign irqReq     = |(flag_reg & enable_reg);

endmodule : uhp_pipe_irq

`default_nettype wire

// File: rtl/uhp_pkg.sv
package uhp_pkg;

	// ****************************************************************
	// Register bus
	// ****************************************************************
	localparam int unsigned DATA_W    = 32;
	localparam int unsigned PADDR_W   = 12;
	localparam int unsigned IDX_W     = 10;
	localparam int unsigned IDX_LSB   = 2;

	// Register indexes, byte address is four times the index
	localparam logic [IDX_W-1:0] FLAG_IDX      = 10'h107;
	localparam logic [IDX_W-1:0] CLR_IDX       = 10'h108;
	localparam logic [IDX_W-1:0] SET_IDX       = 10'h109;
	localparam logic [IDX_W-1:0] PIPE_STRIDE   = 10'h020;
	localparam logic [IDX_W-1:0] PIPE_EN_IDX   = 10'h010;
	localparam logic [IDX_W-1:0] DESC_BASE_IDX = 10'h011;

	// ****************************************************************
	// Event and enable bit layout
	// ****************************************************************
	localparam int unsigned EV_W       = 6;
	localparam int unsigned BIT_STALL  = 5;
	localparam int unsigned BIT_SETUP  = 4;
	localparam int unsigned BIT_PIPE_ERROR_ENABLE   = 3;
	localparam int unsigned BIT_TRANSFER_FAIL_ENABLE = 2;
	localparam int unsigned BIT_BK1    = 1;
	localparam int unsigned BIT_BK0    = 0;
	localparam logic [EV_W-1:0] EV_RESET = 6'h00;

	// ****************************************************************
	// Descriptor layout in system RAM
	// ****************************************************************
	localparam logic [31:0] DESC_ADDR_OFF    = 32'h0000_0000;
	localparam logic [31:0] DESC_SIZE_OFF    = 32'h0000_0004;
	localparam logic [31:0] DESC_BANK_OFF    = 32'h0000_0010;
	localparam logic [31:0] DESC_PIPE_STRIDE = 32'h0000_0020;
	localparam logic [31:0] ADDR_RW_MASK     = 32'hFFFF_FFFC;

	// Size word fields
	localparam int unsigned AUTO_ZERO_LENGTH_PACKET_BIT = 31;
	localparam int unsigned SIZE_HI      = 30;
	localparam int unsigned SIZE_LO      = 28;
	localparam int unsigned MPS_HI       = 27;
	localparam int unsigned MPS_LO       = 14;
	localparam int unsigned BC_HI        = 13;
	localparam int unsigned BC_LO        = 0;
	localparam int unsigned CNT_W        = 14;
	localparam int unsigned PKT_W        = 11;

	// Packet size codes
	localparam logic [2:0]       SIZE_ISO_MIN = 3'h4;
	localparam logic [2:0]       SIZE_MAX     = 3'h7;
	localparam logic [PKT_W-1:0] PKT_BASE     = 11'h008;
	localparam logic [PKT_W-1:0] PKT_FS_MAX   = 11'h3FF;

	// ****************************************************************
	// Descriptor engine states
	// ****************************************************************
	typedef enum logic [4:0] {
		FS_IDLE = 5'b00001,
		FS_ADDR = 5'b00010,
		FS_SIZE = 5'b00100,
		FS_DONE = 5'b01000,
		FS_WB   = 5'b10000
	} uhp_fetch_t;

endpackage : uhp_pkg

// File: tb/uhp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// System memory model
// ********************
module uhp_mem_model
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Request from the block
	input  wire logic        memRead,
	input  wire logic        memWrite,
	input  wire logic [31:0] memAddr,
	input  wire logic [31:0] memWdata,
	// Wait cycles before each answer
	input  wire logic [3:0]  lat,
	// Answer
	output logic      [31:0] memRdata,
	output logic             memAck
);
	logic [31:0] ram [64];
	logic [3:0]  waitCnt;

	// Preload one descriptor word
	task automatic put(input logic [31:0] a, input logic [31:0] d);
		ram[a[7:2]] = d;
	endtask : put

	// Answer after lat cycles, data churns while not answering
	always @(posedge clock)
	begin
		memAck <= 1'b0;
		memRdata <= ~memRdata;
		if (!rst_n)
		begin
			waitCnt <= 4'h0;
			memRdata <= 32'h0000_0000;
		end
		else if ((memRead || memWrite) && !memAck)
		begin
			if (waitCnt >= lat)
			begin
				memAck <= 1'b1;
				waitCnt <= 4'h0;
				memRdata <= ram[memAddr[7:2]];
				if (memWrite)
					ram[memAddr[7:2]] <= memWdata;
			end
			else
				waitCnt <= waitCnt + 4'h1;
		end
	end
endmodule : uhp_mem_model
`default_nettype wire

// File: tb/uhp_pipe_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// Pipe control checker
// ********************
module uhp_pipe_ctrl_props
	import uhp_pkg::*;
(
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               rst_n,
	// APB
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic [PADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0]  prdata,
	input  wire logic               pready,
	input  wire logic               pslverr,
	// Events and interrupt
	input  wire logic               busReset,
	input  wire logic               irq,
	// Memory port
	input  wire logic [31:0]        memAddr,
	input  wire logic               memRead,
	input  wire logic               memWrite,
	input  wire logic [31:0]        memWdata,
	input  wire logic               memAck,
	// Decoded descriptor
	input  wire logic               fetchDone,
	input  wire logic [31:0]        bufAddr,
	input  wire logic [PKT_W-1:0]   maxPacket,
	input  wire logic               isoOnly
);
	// All checks run on the block clock
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	// Bus answer timing and misaligned refusal
	a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("pready not after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_misalign_err: assert property (
		pready && paddr[1:0] != 2'b00 |-> pslverr && prdata == '0)
		else $error("misaligned access not refused");
	// Interrupt and reset
	a_busreset_irq: assert property (busReset |-> ##2 !irq)
		else $error("irq kept after bus reset");
	a_reset_quiet: assert property (disable iff (1'b0)
		!rst_n |=> !pready && !irq && !fetchDone && !memRead)
		else $error("outputs active after reset");
	// Descriptor fetch and accumulate write
	a_buf_align: assert property (bufAddr[1:0] == 2'b00)
		else $error("buffer address low bits not zero");
	a_iso_size: assert property (isoOnly == (maxPacket > 11'h040))
		else $error("iso flag disagrees with packet size");
	a_addr_step: assert property (
		memRead && memAck |=> !memRead || memAddr == $past(memAddr) + 32'h0000_0004)
		else $error("size word not fetched at next word");
	a_done_after: assert property (
		memRead && memAck ##1 !memRead |-> ##1 fetchDone)
		else $error("fetch done not two cycles after last ack");
	a_done_pulse: assert property (fetchDone |=> !fetchDone)
		else $error("fetch done longer than one cycle");
	a_write_hold: assert property (
		memWrite && !memAck |=> memWrite && $stable(memWdata) && $stable(memAddr))
		else $error("write request changed before ack");
endmodule : uhp_pipe_ctrl_props
`default_nettype wire

// File: tb/uhp_pipe_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module uhp_pipe_ctrl_tb;
	import uhp_pkg::*;
	typedef struct packed {
		logic        w;
		logic [11:0] a;
		logic [7:0]  d;
		logic [7:0]  q;
		logic        e;
	} uhp_row_t;
	localparam int unsigned PIPES = 2;
	logic clock, rst_n, psel, penable, pwrite, pready, pslverr, busReset;
	logic fetchStart, fetchBank, accumStart, memRead, memWrite, memAck;
	logic fetchDone, autoZlp, isoOnly, irq, rde;
	logic [PADDR_W-1:0]    paddr;
	logic [31:0]           pwdata, prdata, memAddr, memWdata, memRdata;
	logic [31:0]           bufAddr, rdq, sizeWord;
	logic [PIPES*EV_W-1:0] pipeEvents;
	logic [7:0]            fetchPipe;
	logic [CNT_W-1:0]      accumBytes, multiPacket, byteCount;
	logic [PKT_W-1:0]      maxPacket;
	logic [3:0]            memLat;
	int                    errors, cmp_count;
	// Ordinary accesses: write, address, data, read value, error
	uhp_row_t rows [17] = '{
		'{1'b0, 12'h420, 8'h00, 8'h00, 1'b0},
		'{1'b1, 12'h040, 8'h03, 8'h00, 1'b0},
		'{1'b0, 12'h040, 8'h00, 8'h03, 1'b0},
		'{1'b1, 12'h424, 8'hFF, 8'h00, 1'b0},
		'{1'b0, 12'h420, 8'h00, 8'h3F, 1'b0},
		'{1'b1, 12'h420, 8'h05, 8'h00, 1'b0},
		'{1'b0, 12'h424, 8'h00, 8'h3A, 1'b0},
		'{1'b1, 12'h420, 8'h00, 8'h00, 1'b0},
		'{1'b1, 12'h424, 8'h00, 8'h00, 1'b0},
		'{1'b0, 12'h420, 8'h00, 8'h3A, 1'b0},
		'{1'b1, 12'h4A4, 8'h01, 8'h00, 1'b0},
		'{1'b0, 12'h4A0, 8'h00, 8'h01, 1'b0},
		'{1'b0, 12'h422, 8'h00, 8'h00, 1'b1},
		'{1'b1, 12'h00C, 8'h3F, 8'h00, 1'b1},
		'{1'b0, 12'h00C, 8'h00, 8'h00, 1'b1},
		'{1'b1, 12'h044, 8'h80, 8'h00, 1'b0},
		'{1'b0, 12'h044, 8'h00, 8'h80, 1'b0}
	};

	// Design and memory
	uhp_pipe_ctrl #(.PIPES(PIPES)) i_uhp_pipe_ctrl (
		.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .busReset(busReset),
		.pipeEvents(pipeEvents), .fetchStart(fetchStart),
		.fetchPipe(fetchPipe), .fetchBank(fetchBank),
		.accumStart(accumStart), .accumBytes(accumBytes),
		.memAddr(memAddr), .memRead(memRead), .memWrite(memWrite),
		.memWdata(memWdata), .memRdata(memRdata), .memAck(memAck),
		.fetchDone(fetchDone), .bufAddr(bufAddr), .autoZlp(autoZlp),
		.maxPacket(maxPacket), .isoOnly(isoOnly),
		.multiPacket(multiPacket), .byteCount(byteCount), .irq(irq));
	uhp_mem_model i_uhp_mem_model (
		.clock(clock), .rst_n(rst_n), .memRead(memRead),
		.memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
		.lat(memLat), .memRdata(memRdata), .memAck(memAck));

	// Clock
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// Verdict and end of run
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report

	// Bounded wait for a level
	task automatic waitFor(ref logic s);
		int n;
		n = 0;
		while (s !== 1'b1 && n < 40)
		begin
			@(posedge clock);
			n++;
		end
		if (s !== 1'b1)
		begin
			errors++;
			final_report();
		end
	endtask : waitFor

	// One APB transfer, result in rdq and rde
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		waitFor(pready);
		rdq = prdata;
		rde = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// One-cycle event, then time for the interrupt to follow
	task automatic pulse(input logic [PIPES*EV_W-1:0] v);
		@(posedge clock);
		pipeEvents <= v;
		@(posedge clock);
		pipeEvents <= '0;
		repeat (2) @(posedge clock);
	endtask : pulse

	// Descriptor fetch with request address check
	task automatic fetch(input logic [7:0] p, input logic b, input logic [31:0] ea);
		@(posedge clock);
		fetchStart <= 1'b1;
		fetchPipe <= p;
		fetchBank <= b;
		@(posedge clock);
		fetchStart <= 1'b0;
		waitFor(memRead);
		`CHK("memAddr", ea, memAddr)
		waitFor(fetchDone);
	endtask : fetch

	// Main sequence
	initial
	begin
		errors = 0;
		cmp_count = 0;
		rst_n = 1'b0;
		memLat = 4'h0;
		{psel, penable, pwrite, busReset, fetchStart, fetchBank, accumStart} = '0;
		{paddr, pwdata, pipeEvents, fetchPipe, accumBytes} = '0;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		foreach (rows[i])
		begin
			apb(rows[i].w, rows[i].a, {24'h00_0000, rows[i].d});
			`CHK("pslverr", rows[i].e, rde)
			if (!rows[i].w)
				`CHK("prdata", {24'h00_0000, rows[i].q}, rdq)
		end
		$display("test table done");
		// Masked and unmasked events
		pulse(12'h001);
		`CHK("irq masked", 1'b0, irq)
		apb(1'b0, 12'h41C, '0);
		`CHK("flag", 32'h0000_0001, rdq)
		pulse(12'h002);
		`CHK("irq raised", 1'b1, irq)
		apb(1'b1, 12'h420, 32'h0000_0002);
		repeat (2) @(posedge clock);
		`CHK("irq disabled", 1'b0, irq)
		apb(1'b1, 12'h41C, 32'h0000_0003);
		pulse(12'h040);
		`CHK("irq second pipe", 1'b1, irq)
		apb(1'b1, 12'h49C, 32'h0000_0001);
		repeat (2) @(posedge clock);
		`CHK("irq flag cleared", 1'b0, irq)
		$display("test interrupt done");
		// Disabled pipe keeps an empty mask
		apb(1'b1, 12'h040, 32'h0000_0002);
		apb(1'b1, 12'h424, 32'h0000_003F);
		apb(1'b0, 12'h420, '0);
		`CHK("mask pipe off", 32'h0000_0000, rdq)
		apb(1'b1, 12'h040, 32'h0000_0003);
		apb(1'b0, 12'h424, '0);
		`CHK("mask pipe on", 32'h0000_0000, rdq)
		// Bus reset with a pending request
		pulse(12'h040);
		@(posedge clock);
		busReset <= 1'b1;
		@(posedge clock);
		busReset <= 1'b0;
		apb(1'b0, 12'h4A0, '0);
		`CHK("mask bus reset", 32'h0000_0000, rdq)
		`CHK("irq bus reset", 1'b0, irq)
		$display("test mask clear done");
		// Every size code, prompt and slow memory
		for (int c = 0; c < 8; c++)
		begin
			sizeWord = {c[0], 3'(c), 14'(c), 14'(16383 - c)};
			i_uhp_mem_model.put(32'h0000_0080, 32'h1234_567B);
			i_uhp_mem_model.put(32'h0000_0084, sizeWord);
			memLat <= 4'(c);
			fetch(8'h00, 1'b0, 32'h0000_0080);
			`CHK("bufAddr", 32'h1234_5678, bufAddr)
			`CHK("maxPacket", (c == 7) ? 11'h3FF : 11'(8 << c), maxPacket)
			`CHK("isoOnly", c > 3, isoOnly)
			`CHK("autoZlp", c[0], autoZlp)
			`CHK("multiPacket", 14'(c), multiPacket)
			`CHK("byteCount", 14'(16383 - c), byteCount)
		end
		// Second pipe, second bank, then accumulate
		i_uhp_mem_model.put(32'h0000_00B0, 32'h0000_0100);
		i_uhp_mem_model.put(32'h0000_00B4, sizeWord);
		fetch(8'h01, 1'b1, 32'h0000_00B0);
		`CHK("bufAddr bank1", 32'h0000_0100, bufAddr)
		@(posedge clock);
		accumStart <= 1'b1;
		accumBytes <= 14'h0005;
		@(posedge clock);
		accumStart <= 1'b0;
		waitFor(memWrite);
		`CHK("accum addr", 32'h0000_00B4, memAddr)
		`CHK("accum data", sizeWord + 32'h0001_4000, memWdata)
		repeat (12) @(posedge clock);
		$display("test descriptor done");
		// Reset in mid-run
		apb(1'b1, 12'h424, 32'h0000_0001);
		pulse(12'h001);
		`CHK("irq before reset", 1'b1, irq)
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		`CHK("irq reset", 1'b0, irq)
		apb(1'b0, 12'h424, '0);
		`CHK("mask reset", 32'h0000_0000, rdq)
		$display("test reset done");
		final_report();
	end
endmodule : uhp_pipe_ctrl_tb

bind uhp_pipe_ctrl uhp_pipe_ctrl_props i_uhp_pipe_ctrl_props (
	.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.busReset(busReset), .irq(irq), .memAddr(memAddr), .memRead(memRead),
	.memWrite(memWrite), .memWdata(memWdata), .memAck(memAck),
	.fetchDone(fetchDone), .bufAddr(bufAddr), .maxPacket(maxPacket),
	.isoOnly(isoOnly));
`default_nettype wire
